/* hdl/sp_pkg.sv */
`default_nettype none
// Shared constants of the line-interface signaling port.
package sp_pkg;
  // Register indices as carried by the extended register operation.
  localparam logic [2:0] REG_FIXED_SIGNAL_IO          = 3'h0;
  localparam logic [2:0] REG_BIDIR_SIGNAL_DATA        = 3'h1;
  localparam logic [2:0] REG_BIDIR_SIGNAL_DIRECTION   = 3'h2;
  localparam logic [2:0] REG_THIRD_PIN_DATA_DIRECTION = 3'h3;
  localparam logic [2:0] REG_DEBOUNCE_RING_PERIOD     = 3'h4;

  // Operation byte layout: reset, fixed zero, read, fixed ones, length.
  localparam int         OP_RST_BIT  = 7;
  localparam int         OP_ZERO_BIT = 6;
  localparam int         OP_RW_BIT   = 5;
  localparam int         OP_TAG_MSB  = 4;
  localparam int         OP_TAG_LSB  = 3;
  localparam logic [1:0] OP_TAG_VAL  = 2'h3;
  localparam int         OP_LEN_MSB  = 2;

  // Field positions in the debounce and ring period register, and the third-pin data field.
  localparam int DEB_MSB  = 7;
  localparam int DEB_LSB  = 4;
  localparam int RING_MSB = 3;
  localparam int RING_LSB = 0;
  localparam int THIRD_DATA_LSB = 4;

  // Ring period codes that hold the output at a constant level.
  localparam logic [3:0] RING_HOLD_HIGH = 4'h0;
  localparam logic [3:0] RING_HOLD_LOW  = 4'hf;

  // Value of every register after any reset.
  localparam logic [7:0] REG_RESET = 8'h00;

  // Timing: one interval step, and the clock that counts it.
  localparam int unsigned STEP_MS  = 2;
  localparam int unsigned CLK_HZ   = 10000000;
  localparam int unsigned STEP_CYC = STEP_MS * (CLK_HZ / 1000);

  // Monitored input vector: fixed [7:0], bidir [15:8], third [19:16].
  localparam int          MON_W       = 20;
  localparam logic [19:0] MON_CH12    = 20'h30f0f;
  localparam logic [19:0] MON_CH34    = 20'hcf0f0;
  localparam logic [7:0]  PAIR_MASK2  = 8'h0f;
  localparam logic [7:0]  THIRD_MASK2 = 8'h33;
endpackage
`default_nettype wire

/* hdl/sp_interval_timer.sv */
`default_nettype none
// Cycle counter that pulses once per target cycles without a restart.
module sp_interval_timer #(
  parameter int CW = 18
) (
  input  wire logic          clk_i,
  input  wire logic          resetn_i,
  input  wire logic          restart_i,
  input  wire logic [CW-1:0] target_i,
  output logic               done_o
);
  logic [CW-1:0] count_r;

  if (CW < 2) begin : g_bad_width
    $error("sp_interval_timer: CW must be at least 2");
  end

  // A zero target never fires, so a disabled field stays quiet.
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      count_r <= '0;
      done_o  <= 1'b0;
    end else if (restart_i || (target_i == '0)) begin
      count_r <= '0;
      done_o  <= 1'b0;
    end else if (count_r == target_i - CW'(1)) begin
      count_r <= '0;
      done_o  <= 1'b1;
    end else begin
      count_r <= count_r + CW'(1);
      done_o  <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* hdl/sp_signal_port.sv */
// How it works
// - Fixed-register write drives fixed output pins.
// - Data register read returns input pin levels.
// - Data write drives only output-configured pins.
// - Direction bit 0 input, 1 output.
// - After reset all bidirectional pins are inputs.
// - Third-pin register: data high, direction low.
// - Third-pin read returns input pin levels.
// - Third-pin write drives output-configured pins.
// - Third-pin direction bit 0 input, 1 output.
// - Fifth register holds debounce and ring fields.
// - Stable input loads status and raises interrupt.
// - Debounce code k gives 2k milliseconds.
// - Debounce code zero disables debounce and interrupts.
// - Interrupt pin per channel pair.
// - Fixed-register read returns fixed input pins.
// - Length field sets count, highest register first.
// - Any reset clears all extended registers.
// - Ring code k gives 2k ms; 0 high, 15 low.
`default_nettype none
module sp_signal_port
  import sp_pkg::*;
#(
  parameter int          NUM_CH   = 4,
  parameter int unsigned STEP_CYCLES = STEP_CYC
) (
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  input  wire logic       op_valid_i,
  input  wire logic [7:0] op_byte_i,
  input  wire logic       wr_valid_i,
  input  wire logic [7:0] wr_byte_i,
  output logic            rd_valid_o,
  output logic      [7:0] rd_byte_o,
  output logic            busy_o,
  input  wire logic [7:0] fixed_ind_in_pin_i,
  output logic      [7:0] fixed_cmd_out_pin_o,
  input  wire logic [7:0] bidir_signal_pin_i,
  output logic      [7:0] bidir_signal_pin_o,
  output logic      [7:0] bidir_signal_pin_oe_o,
  input  wire logic [3:0] third_bidir_pin_i,
  output logic      [3:0] third_bidir_pin_o,
  output logic      [3:0] third_bidir_pin_oe_o,
  output logic            irq_pin_channels_low_o,
  output logic            irq_pin_channels_high_o,
  output logic            ring_generator_output_o
);
  localparam int CW = $clog2(15 * STEP_CYCLES + 1);

  if ((NUM_CH != 2 && NUM_CH != 4) || STEP_CYCLES < 2) begin : g_bad_cfg
    $error("sp_signal_port: NUM_CH must be 2 or 4, STEP_CYCLES >= 2");
  end

  typedef enum logic [1:0] {SP_IDLE, SP_WRITE, SP_READ} sp_state_t;

  // Channel masks; the two-channel part keeps channels three and four dead.
  localparam logic [7:0]  PAIR_M  = (NUM_CH == 2) ? PAIR_MASK2 : 8'hff;
  localparam logic [7:0]  THIRD_M = (NUM_CH == 2) ? THIRD_MASK2 : 8'hff;
  localparam logic [19:0] MON_M   = {THIRD_M[7:4], PAIR_M, PAIR_M};

  sp_state_t        state_r;
  sp_state_t        state_nxt;
  logic [2:0]       idx_r;
  logic [2:0]       idx_nxt;
  logic [7:0]       bidir_data_r;
  logic [3:0]       third_data_r;
  logic [7:0]       rd_mux;
  logic [7:0]       deb_ring_r;
  logic [7:0]       fixed_sync1_r;
  logic [7:0]       fixed_sync2_r;
  logic [7:0]       bidir_sync1_r;
  logic [7:0]       bidir_sync2_r;
  logic [3:0]       third_sync1_r;
  logic [3:0]       third_sync2_r;
  logic [MON_W-1:0] mon;
  logic [MON_W-1:0] mon_prev_r;
  logic [MON_W-1:0] stat_r;
  logic [MON_W-1:0] chg;
  logic [3:0]       deb_code;
  logic [3:0]       ring_code;
  logic [3:0]       ring_code_prev_r;
  logic             soft_rst;
  logic             clr;
  logic             op_ok;
  logic             rd_take;
  logic             wr_take;
  logic             deb_done;
  logic             ring_done;
  logic             load;

  // Converts a period code into clock cycles of the given unit.
  function automatic logic [CW-1:0] code_cycles(input logic [3:0] k,
                                                input int unsigned unit);
    return CW'(k) * CW'(unit);
  endfunction

  // Mask applied to a register byte so absent channels read and store zero.
  function automatic logic [7:0] chan_mask(input logic [2:0] idx);
    case (idx)
      REG_FIXED_SIGNAL_IO,
      REG_BIDIR_SIGNAL_DATA,
      REG_BIDIR_SIGNAL_DIRECTION:   chan_mask = PAIR_M;
      REG_THIRD_PIN_DATA_DIRECTION: chan_mask = THIRD_M;
      default:                      chan_mask = 8'hff;
    endcase
  endfunction

  // The software reset bit acts like the reset pin on all channels.
  assign soft_rst  = op_valid_i && op_byte_i[OP_RST_BIT];
  assign clr       = !resetn_i || soft_rst;
  assign op_ok     = op_valid_i && !op_byte_i[OP_RST_BIT] &&
                     !op_byte_i[OP_ZERO_BIT] &&
                     (op_byte_i[OP_TAG_MSB:OP_TAG_LSB] == OP_TAG_VAL);
  assign rd_take   = (state_r == SP_IDLE) && op_ok && op_byte_i[OP_RW_BIT];
  assign wr_take   = (state_r == SP_WRITE) && wr_valid_i;
  assign deb_code  = deb_ring_r[DEB_MSB:DEB_LSB];
  assign ring_code = deb_ring_r[RING_MSB:RING_LSB];

  // Transfer sequencer: length+1 bytes, index counting down to zero.
  always_comb begin
    state_nxt = state_r;
    idx_nxt   = idx_r;
    case (state_r)
      SP_IDLE: begin
        if (op_ok) begin
          state_nxt = op_byte_i[OP_RW_BIT] ? SP_READ : SP_WRITE;
          idx_nxt   = op_byte_i[OP_LEN_MSB:0];
        end
      end
      SP_WRITE: begin
        if (wr_valid_i) begin
          state_nxt = (idx_r == 3'h0) ? SP_IDLE : SP_WRITE;
          idx_nxt   = idx_r - 3'h1;
        end
      end
      SP_READ: begin
        state_nxt = (idx_r == 3'h0) ? SP_IDLE : SP_READ;
        idx_nxt   = idx_r - 3'h1;
      end
      default: begin
        state_nxt = SP_IDLE;
      end
    endcase
  end

  // Sequencer state and busy flag, both registered.
  always_ff @(posedge clk_i) begin
    if (clr) begin
      state_r <= SP_IDLE;
      idx_r   <= 3'h0;
      busy_o  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      idx_r   <= idx_nxt;
      busy_o  <= (state_nxt != SP_IDLE);
    end
  end

  // Register writes; upper channel bits vanish on the small part.
  always_ff @(posedge clk_i) begin
    if (clr) begin
      fixed_cmd_out_pin_o   <= REG_RESET;
      bidir_data_r          <= REG_RESET;
      bidir_signal_pin_oe_o <= REG_RESET;
      third_data_r          <= REG_RESET[3:0];
      third_bidir_pin_oe_o  <= REG_RESET[3:0];
      deb_ring_r            <= REG_RESET;
    end else if (wr_take) begin
      case (idx_r)
        REG_FIXED_SIGNAL_IO:
          fixed_cmd_out_pin_o <= wr_byte_i & PAIR_M;
        REG_BIDIR_SIGNAL_DATA:
          bidir_data_r <= wr_byte_i & PAIR_M;
        REG_BIDIR_SIGNAL_DIRECTION:
          bidir_signal_pin_oe_o <= wr_byte_i & PAIR_M;
        REG_THIRD_PIN_DATA_DIRECTION: begin
          third_data_r         <= wr_byte_i[7:4] & THIRD_M[7:4];
          third_bidir_pin_oe_o <= wr_byte_i[3:0] & THIRD_M[3:0];
        end
        REG_DEBOUNCE_RING_PERIOD:
          deb_ring_r <= wr_byte_i;
        default: begin
        end
      endcase
    end
  end

  // Pin data outputs; the enable alone decides whether a pin is driven.
  always_ff @(posedge clk_i) begin
    if (clr) begin
      bidir_signal_pin_o <= 8'h00;
      third_bidir_pin_o  <= 4'h0;
    end else begin
      bidir_signal_pin_o <= bidir_data_r;
      third_bidir_pin_o  <= third_data_r;
    end
  end

  // Read data: input pins show their status, output pins their data.
  always_comb begin
    case (idx_r)
      REG_FIXED_SIGNAL_IO:
        rd_mux = stat_r[7:0];
      REG_BIDIR_SIGNAL_DATA:
        rd_mux = (stat_r[15:8] & ~bidir_signal_pin_oe_o) |
                 (bidir_data_r & bidir_signal_pin_oe_o);
      REG_BIDIR_SIGNAL_DIRECTION:
        rd_mux = bidir_signal_pin_oe_o;
      REG_THIRD_PIN_DATA_DIRECTION:
        rd_mux = {(stat_r[19:16] & ~third_bidir_pin_oe_o) |
                  (third_data_r & third_bidir_pin_oe_o),
                  third_bidir_pin_oe_o};
      REG_DEBOUNCE_RING_PERIOD:
        rd_mux = deb_ring_r;
      default:
        rd_mux = 8'h00;
    endcase
  end

  // Read stream: one byte per cycle, highest register first.
  always_ff @(posedge clk_i) begin
    if (clr) begin
      rd_valid_o <= 1'b0;
      rd_byte_o  <= 8'h00;
    end else begin
      rd_valid_o <= (state_r == SP_READ);
      rd_byte_o  <= (state_r == SP_READ) ?
                    (rd_mux & chan_mask(idx_r)) : 8'h00;
    end
  end

  // Two-stage synchronisers; only the second stage is looked at.
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      fixed_sync1_r <= 8'h00;
      fixed_sync2_r <= 8'h00;
      bidir_sync1_r <= 8'h00;
      bidir_sync2_r <= 8'h00;
      third_sync1_r <= 4'h0;
      third_sync2_r <= 4'h0;
    end else begin
      fixed_sync1_r <= fixed_ind_in_pin_i;
      fixed_sync2_r <= fixed_sync1_r;
      bidir_sync1_r <= bidir_signal_pin_i;
      bidir_sync2_r <= bidir_sync1_r;
      third_sync1_r <= third_bidir_pin_i;
      third_sync2_r <= third_sync1_r;
    end
  end

  // Only pins configured as inputs are monitored.
  assign mon = {third_sync2_r & ~third_bidir_pin_oe_o,
                bidir_sync2_r & ~bidir_signal_pin_oe_o,
                fixed_sync2_r} & MON_M;
  assign chg  = mon ^ stat_r;
  assign load = (deb_code != 4'h0) && deb_done && (mon == mon_prev_r);

  // Stability timer: any wiggle starts the wait again from zero.
  sp_interval_timer #(.CW(CW)) u_deb_timer (
    .clk_i     (clk_i),
    .resetn_i  (resetn_i),
    .restart_i (clr || (deb_code == 4'h0) ||
                (mon != mon_prev_r) || (mon == stat_r)),
    .target_i  (code_cycles(deb_code, STEP_CYCLES)),
    .done_o    (deb_done)
  );

  // Status registers: follow the pins directly when debounce is off.
  always_ff @(posedge clk_i) begin
    if (clr) begin
      mon_prev_r <= '0;
      stat_r     <= '0;
    end else begin
      mon_prev_r <= mon;
      if (deb_code == 4'h0) begin
        stat_r <= mon;
      end else if (load) begin
        stat_r <= mon;
      end
    end
  end

  // Interrupt levels per channel pair; a new event beats the read clear.
  always_ff @(posedge clk_i) begin
    if (clr) begin
      irq_pin_channels_low_o  <= 1'b0;
      irq_pin_channels_high_o <= 1'b0;
    end else begin
      if (load && |(chg & MON_CH12)) begin
        irq_pin_channels_low_o <= 1'b1;
      end else if (rd_take) begin
        irq_pin_channels_low_o <= 1'b0;
      end
      if (load && |(chg & MON_CH34)) begin
        irq_pin_channels_high_o <= 1'b1;
      end else if (rd_take) begin
        irq_pin_channels_high_o <= 1'b0;
      end
    end
  end

  // Ring generator: toggles every half period, restarts on a code change.
  sp_interval_timer #(.CW(CW)) u_ring_timer (
    .clk_i     (clk_i),
    .resetn_i  (resetn_i),
    .restart_i (clr || (ring_code != ring_code_prev_r)),
    .target_i  (code_cycles(ring_code, STEP_CYCLES / 2)),
    .done_o    (ring_done)
  );

  // Fixed codes hold the level; the others square-wave at 2k ms.
  always_ff @(posedge clk_i) begin
    if (clr) begin
      ring_code_prev_r        <= 4'h0;
      ring_generator_output_o <= 1'b1;
    end else begin
      ring_code_prev_r <= ring_code;
      if (ring_code == RING_HOLD_HIGH) begin
        ring_generator_output_o <= 1'b1;
      end else if (ring_code == RING_HOLD_LOW) begin
        ring_generator_output_o <= 1'b0;
      end else if (ring_done) begin
        ring_generator_output_o <= !ring_generator_output_o;
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  sequence s_read_one;
    rd_take && (op_byte_i[OP_LEN_MSB:0] == 3'h0);
  endsequence

  a_rst_pins_input: assert property (
    @(posedge clk_i) disable iff (1'b0)
    !resetn_i |=> (bidir_signal_pin_oe_o == 8'h00) &&
                  (third_bidir_pin_oe_o == 4'h0))
    else $error("pins not inputs after reset");
  a_fixed_out_write: assert property (
    wr_take && (idx_r == REG_FIXED_SIGNAL_IO) && !soft_rst |=>
      fixed_cmd_out_pin_o == ($past(wr_byte_i) & PAIR_M))
    else $error("fixed output pins missed write");
  a_dir_write: assert property (
    wr_take && (idx_r == REG_BIDIR_SIGNAL_DIRECTION) && !soft_rst |=>
      bidir_signal_pin_oe_o == ($past(wr_byte_i) & PAIR_M))
    else $error("direction write not applied");
  a_read_one_len: assert property (
    s_read_one |=> !soft_rst |=> rd_valid_o ##1 !rd_valid_o)
    else $error("single read not one byte");
  a_deb_off_follow: assert property (
    (deb_code == 4'h0) && !clr |=> stat_r == $past(mon))
    else $error("status not following pins");
  a_deb_off_noirq: assert property (
    (deb_code == 4'h0) && !irq_pin_channels_low_o |=>
      !irq_pin_channels_low_o)
    else $error("interrupt with debounce off");
  a_irq_cause: assert property (
    $rose(irq_pin_channels_high_o) |-> $past(load))
    else $error("interrupt without status load");
  a_ring_high: assert property (
    (ring_code == RING_HOLD_HIGH) [*2] |-> ring_generator_output_o)
    else $error("ring output not held high");
  a_ring_low: assert property (
    ((ring_code == RING_HOLD_LOW) && !clr) [*2] |->
      !ring_generator_output_o)
    else $error("ring output not held low");
  a_upper_zero: assert property (
    (NUM_CH == 2) |-> (fixed_cmd_out_pin_o[7:4] == 4'h0) &&
                      (third_bidir_pin_oe_o[3:2] == 2'h0))
    else $error("absent channel bits set");
endmodule
`default_nettype wire

/* bench/sp_slic_model.sv */
`default_nettype none
// Line interface side of the port: indication levels and shared pins.
module sp_slic_model (
  input  wire logic [7:0] ind_lvl_i,
  input  wire logic [7:0] bid_lvl_i,
  input  wire logic [3:0] thd_lvl_i,
  input  wire logic [7:0] bid_o_i,
  input  wire logic [7:0] bid_oe_i,
  input  wire logic [3:0] thd_o_i,
  input  wire logic [3:0] thd_oe_i,
  output logic      [7:0] fixed_in_o,
  output logic      [7:0] bid_wire_o,
  output logic      [3:0] thd_wire_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // The line circuit drives only the pins the codec has released, so a
  // driven pin reads back the codec's own level and no clash is modelled.
  assign fixed_in_o = ind_lvl_i;
  assign bid_wire_o = (bid_oe_i & bid_o_i) | (~bid_oe_i & bid_lvl_i);
  assign thd_wire_o = (thd_oe_i & thd_o_i) | (~thd_oe_i & thd_lvl_i);
endmodule
`default_nettype wire

/* bench/tb_slic_signaling_port.sv */
`default_nettype none
module tb_slic_signaling_port;
  timeunit 1ns;
  timeprecision 1ns;
  import sp_pkg::*;
  // A short interval step keeps every debounce and ring count brief.
  localparam int S = 20;
  logic       clk_i      = 1'b0;
  logic       resetn_i   = 1'b0;
  logic       op_valid_i = 1'b0;
  logic       wr_valid_i = 1'b0;
  logic [7:0] op_byte_i  = 8'h00;
  logic [7:0] wr_byte_i  = 8'h00;
  logic [7:0] ind_lvl    = 8'h00;
  logic [7:0] bid_lvl    = 8'h00;
  logic [3:0] thd_lvl    = 4'h0;
  logic       rd_valid_o, busy_o, irq_lo, irq_hi, ring_o;
  logic [7:0] rd_byte_o, fcmd, bid_o, bid_oe, fin, bid_w;
  logic [3:0] thd_o, thd_oe, thd_w;
  logic [7:0] rq [8];
  int         n_errors = 0;
  int         samples_checked = 0;

  // Free running clock, 100 ns period.
  always #50 clk_i = ~clk_i;

  sp_signal_port #(.NUM_CH(4), .STEP_CYCLES(S)) u_dut (
    .clk_i(clk_i), .resetn_i(resetn_i),
    .op_valid_i(op_valid_i), .op_byte_i(op_byte_i),
    .wr_valid_i(wr_valid_i), .wr_byte_i(wr_byte_i),
    .rd_valid_o(rd_valid_o), .rd_byte_o(rd_byte_o), .busy_o(busy_o),
    .fixed_ind_in_pin_i(fin), .fixed_cmd_out_pin_o(fcmd),
    .bidir_signal_pin_i(bid_w), .bidir_signal_pin_o(bid_o),
    .bidir_signal_pin_oe_o(bid_oe), .third_bidir_pin_i(thd_w),
    .third_bidir_pin_o(thd_o), .third_bidir_pin_oe_o(thd_oe),
    .irq_pin_channels_low_o(irq_lo), .irq_pin_channels_high_o(irq_hi),
    .ring_generator_output_o(ring_o));

  sp_slic_model u_slic (
    .ind_lvl_i(ind_lvl), .bid_lvl_i(bid_lvl), .thd_lvl_i(thd_lvl),
    .bid_o_i(bid_o), .bid_oe_i(bid_oe), .thd_o_i(thd_o),
    .thd_oe_i(thd_oe), .fixed_in_o(fin), .bid_wire_o(bid_w),
    .thd_wire_o(thd_w));

  // Verdict and end of run; every hang cut short also lands here.
  task automatic end_sim();
    $display("checked %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic timeout(input string nm);
    n_errors++;
    $display("Error %s expected response seen none", nm);
    end_sim();
  endtask

  // Compare of an 8-bit value; four-state so an unknown never matches.
  task automatic chk8(input string nm, input logic [7:0] e, g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Compare of a measured cycle count against a window.
  task automatic chk_n(input string nm, input int lo, hi, g);
    samples_checked++;
    if (g < lo || g > hi) begin
      n_errors++;
      $display("Error %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask

  // Inputs always change 1 ns after the rising edge.
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic wait_idle();
    int i;
    for (i = 0; i < 40 && busy_o !== 1'b0; i++) cyc(1);
    if (i == 40) timeout("busy");
  endtask

  task automatic send_op(input logic [7:0] b);
    op_valid_i = 1'b1;
    op_byte_i  = b;
    cyc(1);
    op_valid_i = 1'b0;
  endtask

  // Write registers len down to 0; byte i of d goes to register i.
  task automatic xwr(input logic [2:0] len, input logic [63:0] d);
    send_op({3'b000, OP_TAG_VAL, len});
    for (int i = len; i >= 0; i--) begin
      wr_valid_i = 1'b1;
      wr_byte_i  = d[8*i +: 8];
      cyc(1);
    end
    wr_valid_i = 1'b0;
    wait_idle();
  endtask

  // Read registers len down to 0 into rq, indexed by register.
  task automatic xrd(input logic [2:0] len);
    int k;
    k = len;
    send_op({3'b001, OP_TAG_VAL, len});
    for (int t = 0; t < 40 && k >= 0; t++) begin
      if (rd_valid_o === 1'b1) begin
        rq[k] = rd_byte_o;
        k--;
      end
      cyc(1);
    end
    if (k >= 0) timeout("read");
    wait_idle();
  endtask

  // After reset no bidirectional pin is driven and registers 0 to 5, mapped or not, read 0.
  task automatic t_reset();
    chk8("bid_oe", 8'h00, bid_oe);
    chk8("thd_oe", 8'h00, {4'h0, thd_oe});
    chk8("fcmd", 8'h00, fcmd);
    chk8("ring", 8'h01, {7'h0, ring_o});
    xrd(3'h5);
    for (int i = 0; i < 6; i++) chk8("reg", 8'h00, rq[i]);
  endtask

  // Fixed outputs follow writes; with debounce off no interrupt appears.
  task automatic t_fixed();
    xwr(3'h0, 64'ha5);
    chk8("fcmd", 8'ha5, fcmd);
    ind_lvl = 8'h3c;
    cyc(6);
    chk8("irq_lo", 8'h00, {7'h0, irq_lo});
    chk8("irq_hi", 8'h00, {7'h0, irq_hi});
    xrd(3'h0);
    chk8("reg0", 8'h3c, rq[0]);
  endtask

  // Mixed directions: outputs drive written data, inputs report levels.
  task automatic t_bidir();
    bid_lvl = 8'ha0;
    thd_lvl = 4'hc;
    xwr(3'h3, 64'h530f5a00);
    chk8("bid_oe", 8'h0f, bid_oe);
    chk8("bid_out", 8'h0a, bid_o & bid_oe);
    chk8("thd_oe", 8'h03, {4'h0, thd_oe});
    chk8("thd_out", 8'h01, {4'h0, thd_o & thd_oe});
    cyc(6);
    xrd(3'h3);
    chk8("reg3", 8'hd3, rq[3]);
    chk8("reg2", 8'h0f, rq[2]);
    chk8("reg1", 8'haa, rq[1]);
  endtask

  // Software reset returns every bidirectional pin to input in mid-configuration.
  task automatic t_soft();
    send_op(8'h80);
    chk8("bid_oe", 8'h00, bid_oe);
    chk8("thd_oe", 8'h00, {4'h0, thd_oe});
    chk8("fcmd", 8'h00, fcmd);
    // Released pins need the synchronisers and status to settle first.
    cyc(4);
    xrd(3'h3);
    chk8("reg2", 8'h00, rq[2]);
    chk8("reg3", {thd_lvl, 4'h0}, rq[3]);
  endtask

  // A glitch restarts the timer; each channel pair has its own pin.
  task automatic t_deb(input int k);
    int n;
    xwr(3'h4, {24'h0, k[3:0], 4'h0, 32'h0});
    xrd(3'h0);
    ind_lvl[0] = ~ind_lvl[0];
    cyc(k * S / 2);
    ind_lvl[1] = ~ind_lvl[1];
    for (n = 0; n < 40 * k && irq_lo !== 1'b1; n++) cyc(1);
    if (n == 40 * k) timeout("irq_lo");
    chk_n("deb_lo", k * S, k * S + 6, n);
    chk8("irq_hi", 8'h00, {7'h0, irq_hi});
    xrd(3'h0);
    chk8("reg0", ind_lvl, rq[0]);
    chk8("irq_clr", 8'h00, {7'h0, irq_lo});
    ind_lvl[4] = ~ind_lvl[4];
    for (n = 0; n < 40 * k && irq_hi !== 1'b1; n++) cyc(1);
    if (n == 40 * k) timeout("irq_hi");
    chk_n("deb_hi", k * S, k * S + 6, n);
    chk8("irq_lo", 8'h00, {7'h0, irq_lo});
    xrd(3'h0);
  endtask

  // Ring half period and the two hold codes.
  task automatic t_ring();
    int   n;
    logic r;
    xwr(3'h4, {24'h0, 8'h32, 32'h0});
    xrd(3'h4);
    chk8("reg4", 8'h32, rq[4]);
    r = ring_o;
    for (n = 0; n < 100 && ring_o === r; n++) cyc(1);
    r = ring_o;
    for (n = 0; n < 100 && ring_o === r; n++) cyc(1);
    chk_n("ring_half", S, S, n);
    for (int c = 0; c < 2; c++) begin
      xwr(3'h4, {24'h0, 4'h0, (c == 0) ? RING_HOLD_HIGH : RING_HOLD_LOW,
                 32'h0});
      n = 0;
      repeat (60) begin
        cyc(1);
        if (ring_o !== (c == 0)) n++;
      end
      chk_n("ring_hold", 0, 0, n);
    end
  endtask

  // Main sequence: reset for two cycles, then each scenario in turn.
  initial begin
    cyc(2);
    resetn_i = 1'b1;
    cyc(3);
    t_reset();
    t_fixed();
    t_bidir();
    t_soft();
    t_deb(1);
    t_deb(3);
    t_ring();
    end_sim();
  end
endmodule
`default_nettype wire
